// *** supervisory_table_checksum_defines.vh ***
`ifndef SUPERVISORY_TABLE_CHECKSUM_DEFINES_VH
`define SUPERVISORY_TABLE_CHECKSUM_DEFINES_VH

// ****************************************************************
// register word indices (byte address = 4 * index)
// ****************************************************************
`define IDX_MAIN_OSC_TRIM 10'h034
`define IDX_MAIN_OSC_GAIN 10'h038
`define IDX_CALL_CMD 10'h040
`define IDX_CALL_STATUS 10'h041
`define IDX_SLOW_OSC_TRIM 10'h042
`define IDX_CLOCK_SELECT 10'h043
`define IDX_PARAM_BASE 10'h0f8
`define IDX_PARAM_HI7 7'h1f

// ****************************************************************
// parameter block byte positions inside f8h..ffh
// ****************************************************************
`define PARAM_KEY_LOW 3'h0
`define PARAM_KEY_HIGH 3'h1
`define PARAM_BLOCK_SELECTOR 3'h2

// ****************************************************************
// call codes and keys
// ****************************************************************
`define OPER_KEY 8'h3a
`define OP_TABLE_READ 8'h06
`define OP_CHECKSUM 8'h07

// ****************************************************************
// status field positions
// ****************************************************************
`define STAT_BUSY 0
`define STAT_KEY_ERR 1
`define STAT_BAD_OP 2
`define STAT_RET_A_LSB 8
`define STAT_RET_X_LSB 16

// ****************************************************************
// clock select field positions
// ****************************************************************
`define SEL_ITMR_SLOW 0
`define SEL_TCAP_SLOW 1

// ****************************************************************
// table space locations and reset values
// ****************************************************************
`define TBL_MAIN_TRIM_3V3 6'h14
`define TBL_SLOW_TRIM_3V3 6'h18
`define RST_MAIN_OSC_TRIM 8'h80
`define RST_MAIN_OSC_GAIN 8'h40
`define RST_SLOW_OSC_TRIM 8'h80
`define RET_NONE 8'hff
`define BLOCK_SHIFT 6
`define ALL_BLOCKS 9'h100

`endif

// *** supervisory_table_checksum.v ***
// Overview of operation
// [R1] parameter block is the eight bytes f8h..ffh; arguments in, results out there
// [R2] caller writes key 3ah into the key-low byte before a flash call
// [R3] caller writes stack pointer plus 3 into the key-high byte; the call never checks key-high, only key-low
// [R4] accumulator code 06h selects a table read
// [R5] table 0 leaves silicon id high byte at f8, low byte at f9
// [R6] table 2 gives main trims in fch..ffh, table 3 slow trims in f8h..fbh
// [R7] checksum is a 16-bit sum over chosen blocks starting at block zero
// [R8] selector gives block count; one means block 0, zero means 256 blocks
// [R9] checksum low byte returns in key-low, high byte in key-high
// [R10] each byte adds into low sum, carry into high sum, count times 64
// [R11] power-on loads the 3.30 v trim set; firmware retunes later
// [R12] main trim at 0x34 and gain at 0x38 are software writable
// [R13] slow oscillator runs in suspend and can clock interval and capture timers
// [R14] table read uses only the low three selector bits
// [R15] results are written before completion; parameters locked while busy
`include "supervisory_table_checksum_defines.vh"
`default_nettype none

module supervisory_table_checksum #(
  parameter [7:0] REV_ID = 8'h01,       // arbitrary value
  parameter [7:0] FAMILY_ID = 8'h02,    // arbitrary value
  parameter [7:0] INT_REV_COUNT = 8'h00 // arbitrary value
) (
  input wire CLK_IN,
  input wire NRST_IN,
  input wire CE_IN,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [11:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  output reg FLASH_REQ_OUT,
  output reg FLASH_TABLE_OUT,
  output reg [13:0] FLASH_ADDR_OUT,
  input wire FLASH_ACK_IN,
  input wire [7:0] FLASH_DATA_IN,
  output reg [7:0] MAIN_OSC_TRIM_OUT,
  output reg [7:0] MAIN_OSC_GAIN_OUT,
  output reg [7:0] SLOW_OSC_TRIM_OUT,
  output reg SLOW_OSC_EN_OUT,
  output reg INTERVAL_TIMER_CLOCK_SLOW_OUT,
  output reg CAPTURE_TIMER_CLOCK_SLOW_OUT
);

  // ****************************************************************
  // states
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_BOOT_MAIN = 3'd1;
  localparam [2:0] ST_BOOT_SLOW = 3'd2;
  localparam [2:0] ST_TABLE = 3'd3;
  localparam [2:0] ST_SUM = 3'd4;

  reg [2:0] state_r;
  reg [7:0] param_r [0:7];
  reg [2:0] table_r;
  reg [14:0] cnt_r;
  reg [14:0] last_r;
  reg [7:0] sum_lo_r;
  reg [7:0] sum_hi_r;
  reg key_err_r;
  reg bad_op_r;
  reg [7:0] ret_a_r;
  reg [7:0] ret_x_r;
  reg [31:0] rd_nxt;
  reg [8:0] sum_lo_nxt;
  reg [8:0] nblk_nxt;
  integer i;

  wire [9:0] idx = WB_ADR_I[11:2];
  wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wb_wr = wb_req & WB_WE_I & WB_SEL_I[0];
  wire busy = (state_r != ST_IDLE);
  wire is_param = (idx[9:3] == `IDX_PARAM_HI7);
  wire [7:0] wdat = WB_DAT_I[7:0];
  wire [7:0] blk_sel = param_r[`PARAM_BLOCK_SELECTOR];

  // ****************************************************************
  // read mux
  // ****************************************************************
  // unmapped reads answer zero so software sees a defined value
  always @* begin
    rd_nxt = 32'h0000_0000;
    if (is_param) begin
      rd_nxt[7:0] = param_r[idx[2:0]]; // [R1]
    end else begin
      case (idx)
        `IDX_MAIN_OSC_TRIM: rd_nxt[7:0] = MAIN_OSC_TRIM_OUT; // [R12]
        `IDX_MAIN_OSC_GAIN: rd_nxt[7:0] = MAIN_OSC_GAIN_OUT; // [R12]
        `IDX_SLOW_OSC_TRIM: rd_nxt[7:0] = SLOW_OSC_TRIM_OUT;
        `IDX_CLOCK_SELECT: begin
          rd_nxt[`SEL_ITMR_SLOW] = INTERVAL_TIMER_CLOCK_SLOW_OUT;
          rd_nxt[`SEL_TCAP_SLOW] = CAPTURE_TIMER_CLOCK_SLOW_OUT;
        end
        `IDX_CALL_STATUS: begin
          rd_nxt[`STAT_BUSY] = busy;
          rd_nxt[`STAT_KEY_ERR] = key_err_r;
          rd_nxt[`STAT_BAD_OP] = bad_op_r;
          rd_nxt[`STAT_RET_A_LSB +: 8] = ret_a_r;
          rd_nxt[`STAT_RET_X_LSB +: 8] = ret_x_r;
        end
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // checksum arithmetic and block count
  // ****************************************************************
  // a zero selector means the whole bank, so the count needs nine bits
  always @* begin
    sum_lo_nxt = {1'b0, sum_lo_r} + {1'b0, FLASH_DATA_IN}; // [R10]
    nblk_nxt = (blk_sel == 8'h00) ? `ALL_BLOCKS : {1'b0, blk_sel}; // [R8]
  end

  // ****************************************************************
  // bus slave, call sequencer and oscillator registers
  // ****************************************************************
  always @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state_r <= ST_BOOT_MAIN;
      for (i = 0; i < 8; i = i + 1) begin
        param_r[i] <= 8'h00;
      end
      table_r <= 3'h0;
      cnt_r <= 15'h0000;
      last_r <= 15'h0000;
      sum_lo_r <= 8'h00;
      sum_hi_r <= 8'h00;
      key_err_r <= 1'b0;
      bad_op_r <= 1'b0;
      ret_a_r <= `RET_NONE;
      ret_x_r <= `RET_NONE;
      WB_DAT_O <= 32'h0000_0000;
      WB_ACK_O <= 1'b0;
      FLASH_REQ_OUT <= 1'b0;
      FLASH_TABLE_OUT <= 1'b0;
      FLASH_ADDR_OUT <= 14'h0000;
      MAIN_OSC_TRIM_OUT <= `RST_MAIN_OSC_TRIM;
      MAIN_OSC_GAIN_OUT <= `RST_MAIN_OSC_GAIN;
      SLOW_OSC_TRIM_OUT <= `RST_SLOW_OSC_TRIM;
      SLOW_OSC_EN_OUT <= 1'b0;
      INTERVAL_TIMER_CLOCK_SLOW_OUT <= 1'b0;
      CAPTURE_TIMER_CLOCK_SLOW_OUT <= 1'b0;
    end else if (CE_IN) begin
      // slow oscillator is off in reset, then never stops from the first enabled cycle; it also serves suspend and power sequencing
      SLOW_OSC_EN_OUT <= 1'b1; // [R13]
      // bus: one wait state, ack drops the cycle after it is given
      WB_ACK_O <= wb_req;
      if (wb_req) begin
        WB_DAT_O <= rd_nxt;
      end
      if (wb_wr) begin
        // parameter area is frozen while a call runs
        if (is_param && !busy) begin
          param_r[idx[2:0]] <= wdat; // [R15]
        end
        case (idx)
          `IDX_MAIN_OSC_TRIM: MAIN_OSC_TRIM_OUT <= wdat; // [R12]
          `IDX_MAIN_OSC_GAIN: MAIN_OSC_GAIN_OUT <= wdat; // [R12]
          `IDX_SLOW_OSC_TRIM: SLOW_OSC_TRIM_OUT <= wdat;
          `IDX_CLOCK_SELECT: begin
            INTERVAL_TIMER_CLOCK_SLOW_OUT <= wdat[`SEL_ITMR_SLOW]; // [R13]
            CAPTURE_TIMER_CLOCK_SLOW_OUT <= wdat[`SEL_TCAP_SLOW]; // [R13]
          end
          default: begin
          end
        endcase
      end
      // sequencer: one flash request at a time, req drops for a cycle after ack
      case (state_r)
        ST_IDLE: begin
          if (wb_wr && idx == `IDX_CALL_CMD) begin
            key_err_r <= 1'b0;
            bad_op_r <= 1'b0;
            cnt_r <= 15'h0000;
            if (param_r[`PARAM_KEY_LOW] != `OPER_KEY) begin
              key_err_r <= 1'b1; // [R2]
            end else if (wdat == `OP_TABLE_READ) begin
              table_r <= blk_sel[2:0]; // [R4] [R14]
              state_r <= ST_TABLE;
            end else if (wdat == `OP_CHECKSUM) begin
              sum_lo_r <= 8'h00;
              sum_hi_r <= 8'h00;
              last_r <= {nblk_nxt, 6'h00} - 15'h0001; // [R8] [R10]
              state_r <= ST_SUM;
            end else begin
              bad_op_r <= 1'b1;
            end
          end
        end
        ST_BOOT_MAIN, ST_BOOT_SLOW: begin
          if (!FLASH_REQ_OUT) begin
            FLASH_REQ_OUT <= 1'b1;
            FLASH_TABLE_OUT <= 1'b1;
            FLASH_ADDR_OUT <= {8'h00, (state_r == ST_BOOT_MAIN) ?
                               `TBL_MAIN_TRIM_3V3 : `TBL_SLOW_TRIM_3V3};
          end else if (FLASH_ACK_IN) begin
            FLASH_REQ_OUT <= 1'b0;
            if (state_r == ST_BOOT_MAIN) begin
              MAIN_OSC_TRIM_OUT <= FLASH_DATA_IN; // [R11]
              state_r <= ST_BOOT_SLOW;
            end else begin
              SLOW_OSC_TRIM_OUT <= FLASH_DATA_IN; // [R11]
              state_r <= ST_IDLE;
            end
          end
        end
        ST_TABLE: begin
          if (!FLASH_REQ_OUT) begin
            FLASH_REQ_OUT <= 1'b1;
            FLASH_TABLE_OUT <= 1'b1;
            FLASH_ADDR_OUT <= {8'h00, table_r, cnt_r[2:0]};
          end else if (FLASH_ACK_IN) begin
            FLASH_REQ_OUT <= 1'b0;
            // row byte n lands at f8h+n: id high at f8, trims where tabled
            param_r[cnt_r[2:0]] <= FLASH_DATA_IN; // [R1] [R5] [R6]
            cnt_r <= cnt_r + 15'h0001;
            if (cnt_r[2:0] == 3'h7) begin
              ret_a_r <= (table_r == 3'h0) ? REV_ID :
                         (table_r == 3'h1) ? INT_REV_COUNT : `RET_NONE;
              ret_x_r <= (table_r == 3'h0) ? FAMILY_ID : `RET_NONE;
              state_r <= ST_IDLE; // [R15]
            end
          end
        end
        ST_SUM: begin
          if (!FLASH_REQ_OUT) begin
            FLASH_REQ_OUT <= 1'b1;
            FLASH_TABLE_OUT <= 1'b0;
            FLASH_ADDR_OUT <= cnt_r[13:0]; // [R7]
          end else if (FLASH_ACK_IN) begin
            FLASH_REQ_OUT <= 1'b0;
            sum_lo_r <= sum_lo_nxt[7:0]; // [R10]
            sum_hi_r <= sum_hi_r + {7'h00, sum_lo_nxt[8]}; // [R10]
            cnt_r <= cnt_r + 15'h0001;
            if (cnt_r == last_r) begin
              param_r[`PARAM_KEY_LOW] <= sum_lo_nxt[7:0]; // [R9]
              param_r[`PARAM_KEY_HIGH] <= sum_hi_r + {7'h00, sum_lo_nxt[8]}; // [R9]
              state_r <= ST_IDLE; // [R15]
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule // supervisory_table_checksum

`default_nettype wire

// *** sup_props.sv ***
`default_nettype none
module sup_props (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic CE_IN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [11:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic FLASH_REQ_OUT,
  input wire logic FLASH_TABLE_OUT,
  input wire logic [13:0] FLASH_ADDR_OUT,
  input wire logic FLASH_ACK_IN,
  input wire logic [7:0] MAIN_OSC_TRIM_OUT,
  input wire logic [7:0] MAIN_OSC_GAIN_OUT,
  input wire logic SLOW_OSC_EN_OUT,
  input wire logic INTERVAL_TIMER_CLOCK_SLOW_OUT,
  input wire logic CAPTURE_TIMER_CLOCK_SLOW_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  // taken request and taken write with lane 0 enabled
  wire tk = WB_CYC_I && WB_STB_I && !WB_ACK_O && CE_IN;
  wire wt = tk && WB_WE_I && WB_SEL_I[0];
  property p_ack; tk |=> WB_ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("request not acked");
  property p_ack1; WB_ACK_O && CE_IN |=> !WB_ACK_O; endproperty
  a_ack1: assert property (p_ack1) else $error("ack too long");
  property p_trim; wt && WB_ADR_I == 12'h0d0 |=> MAIN_OSC_TRIM_OUT == $past(WB_DAT_I[7:0]);
  endproperty
  a_trim: assert property (p_trim) else $error("trim not written");
  property p_gain; wt && WB_ADR_I == 12'h0e0 |=> MAIN_OSC_GAIN_OUT == $past(WB_DAT_I[7:0]);
  endproperty
  a_gain: assert property (p_gain) else $error("gain not written");
  property p_csel; wt && WB_ADR_I == 12'h10c |=>
    {CAPTURE_TIMER_CLOCK_SLOW_OUT, INTERVAL_TIMER_CLOCK_SLOW_OUT} == $past(WB_DAT_I[1:0]);
  endproperty
  a_csel: assert property (p_csel) else $error("clock select wrong");
  property p_slow; SLOW_OSC_EN_OUT |=> SLOW_OSC_EN_OUT; endproperty
  a_slow: assert property (p_slow) else $error("slow oscillator stopped");
  // a request must stand still until the flash answers
  property p_hold; FLASH_REQ_OUT && !FLASH_ACK_IN && CE_IN |=>
    FLASH_REQ_OUT && $stable(FLASH_ADDR_OUT); endproperty
  a_hold: assert property (p_hold) else $error("flash request moved");
  property p_drop; FLASH_REQ_OUT && FLASH_ACK_IN && CE_IN |=> !FLASH_REQ_OUT; endproperty
  a_drop: assert property (p_drop) else $error("flash request kept");
  property p_trow; FLASH_REQ_OUT && FLASH_TABLE_OUT |-> FLASH_ADDR_OUT[13:6] == 8'h00;
  endproperty
  a_trow: assert property (p_trow) else $error("table address out of row");
  property p_umap; tk && !WB_WE_I && WB_ADR_I == 12'h200 |=> WB_DAT_O == 32'h0; endproperty
  a_umap: assert property (p_umap) else $error("unmapped read not zero");
endmodule // sup_props
bind supervisory_table_checksum sup_props u_props (.*);
`default_nettype wire

// *** flash_model.sv ***
`default_nettype none
module flash_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic tsel,
  input wire logic [13:0] addr,
  output logic ack,
  output logic [7:0] data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wt;
  function automatic logic [7:0] fdat(input logic t, input logic [13:0] a);
    fdat = t ? {2'b01, a[5:0]} : (a[7:0] ^ {a[13:8], 2'b11});
  endfunction
  // waits 0..3 cycles by address; data toggles whenever it is not valid
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      data <= 8'h00;
      wt <= 2'h0;
    end else if (req && !ack && wt >= addr[1:0]) begin
      ack <= 1'b1;
      data <= fdat(tsel, addr);
      wt <= 2'h0;
    end else begin
      ack <= 1'b0;
      data <= ~data;
      wt <= (req && !ack) ? wt + 2'h1 : 2'h0;
    end
  end
endmodule // flash_model
`default_nettype wire

// *** tb_top.sv ***
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, cyc, stb, we, ack, freq, ftab, fack, sen, itc, ctc;
  logic [3:0] sel;
  logic [11:0] adr;
  logic [13:0] fadr;
  logic [31:0] dw, dato, dr, st, s;
  logic [7:0] fd, trim, gain, strim;
  int fails, compares;
  supervisory_table_checksum dut (.CLK_IN(clk), .NRST_IN(nrst), .CE_IN(1'b1),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dw), .WB_DAT_O(dato), .WB_ACK_O(ack), .FLASH_REQ_OUT(freq),
    .FLASH_TABLE_OUT(ftab), .FLASH_ADDR_OUT(fadr), .FLASH_ACK_IN(fack),
    .FLASH_DATA_IN(fd), .MAIN_OSC_TRIM_OUT(trim), .MAIN_OSC_GAIN_OUT(gain),
    .SLOW_OSC_TRIM_OUT(strim), .SLOW_OSC_EN_OUT(sen),
    .INTERVAL_TIMER_CLOCK_SLOW_OUT(itc), .CAPTURE_TIMER_CLOCK_SLOW_OUT(ctc));
  flash_model fl (.clk(clk), .rst_n(nrst), .req(freq), .tsel(ftab), .addr(fadr),
    .ack(fack), .data(fd));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // one classic cycle; ack and read data are taken at the rising edge that sees ack,
  // the request is released by that same edge so cyc stays low for a cycle between calls
  task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dw <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    dr = dato;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task idle;
    do bus(1'b0, 12'h104, 8'h00); while (dr[0] !== 1'b0);
    st = dr;
  endtask
  task call(input logic [7:0] k, input logic [7:0] b, input logic [7:0] op);
    bus(1'b1, 12'h3e0, k);
    bus(1'b1, 12'h3e4, 8'h23);
    bus(1'b1, 12'h3e8, b);
    bus(1'b1, 12'h100, op);
    idle;
  endtask
  task close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task t_boot;
    idle;
    `CHK(trim, fl.fdat(1'b1, 14'h14))
    `CHK(strim, fl.fdat(1'b1, 14'h18))
    `CHK(gain, 8'h40)
    $display("test boot done");
  endtask
  task t_regs;
    bus(1'b1, 12'h0d0, 8'ha5);
    bus(1'b0, 12'h0d0, 8'h00);
    `CHK(dr, 32'h000000a5)
    bus(1'b1, 12'h0e0, 8'hff);
    `CHK(gain, 8'hff)
    bus(1'b1, 12'h10c, 8'h03);
    `CHK({ctc, itc, sen}, 3'b111)
    bus(1'b1, 12'h10c, 8'h02);
    `CHK({ctc, itc}, 2'b10)
    bus(1'b1, 12'h108, 8'h5c);
    bus(1'b0, 12'h108, 8'h00);
    `CHK(dr, 32'h0000005c)
    `CHK(strim, 8'h5c)
    bus(1'b0, 12'h200, 8'h00);
    `CHK(dr, 32'h0)
    $display("test regs done");
  endtask
  task t_table;
    for (int t = 0; t < 8; t++) begin
      call(8'h3a, 8'hf8 | t[7:0], 8'h06);
      `CHK(st[15:8], (t == 0) ? 8'h01 : (t == 1) ? 8'h00 : 8'hff)
      `CHK(st[23:16], (t == 0) ? 8'h02 : 8'hff)
      for (int n = 0; n < 8; n++) begin
        bus(1'b0, 12'h3e0 + 12'(4 * n), 8'h00);
        `CHK(dr[7:0], fl.fdat(1'b1, 14'(8 * t + n)))
      end
    end
    $display("test table done");
  endtask
  task t_err;
    call(8'h00, 8'h00, 8'h06);
    `CHK(st[2:1], 2'b01)
    call(8'h3a, 8'h00, 8'h09);
    `CHK(st[2:1], 2'b10)
    $display("test errors done");
  endtask
  task t_sum(input int n);
    s = 32'h0;
    call(8'h3a, n[7:0], 8'h07);
    for (int a = 0; a < n * 64; a++) s = s + fl.fdat(1'b0, 14'(a));
    bus(1'b0, 12'h3e0, 8'h00);
    `CHK(dr[7:0], s[7:0])
    bus(1'b0, 12'h3e4, 8'h00);
    `CHK(dr[7:0], s[15:8])
    $display("test checksum done");
  endtask
  initial begin
    fails = 0; compares = 0; nrst = 1'b0;
    cyc = 1'b0; stb = 1'b0; we = 1'b0; sel = 4'h1; adr = 12'h0; dw = 32'h0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_boot; t_regs; t_table; t_err; t_sum(1); t_sum(3);
    close_out;
  end
  // watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    close_out;
  end
endmodule // tb_top
`default_nettype wire
